// file: rtl/mmct_channel.sv
// one 16-bit multimode counter/timer channel with AXI4-Lite registers
// field inputs are asynchronous and pass two flip-flops first
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
`include "mmct_params.svh"
module mmct_channel
  import mmct_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        gate_reload_input,
  input  wire logic        clock_event_input,
  input  wire logic        trigger_index_input,
  output logic             channel_output,
  output logic             irq_req
);
  // cycle counts derived from times, least times round up
  localparam int PULSE_I = (`MMCT_PULSE_NS + `MMCT_CLK_NS - 1) / `MMCT_CLK_NS;
  localparam int DEB_I   = (`MMCT_DEB_NS + `MMCT_CLK_NS - 1) / `MMCT_CLK_NS;
  localparam logic [8:0] PULSE_C = 9'(PULSE_I);
  localparam logic [8:0] DEB_C   = 9'(DEB_I);

  logic [2:0]  s1_q, s2_q, s3_q;   // sync stages and previous level
  logic [3:0]  div_q;              // internal tick divider
  logic        dtick_q;            // internal tick pulse
  logic [15:0] ctrl_q;             // mode and options
  logic [15:0] pre1_q, pre2_q;     // presets
  logic [15:0] ivec_q;             // interrupt vector
  logic        swtrig_q;           // software trigger pulse
  mmct_state_t st_q;               // sequencer state
  logic [15:0] cnt_q;              // live count
  logic [15:0] rb_q;               // latched measurement
  logic        act_q;              // waveform active level
  logic        done_q, ev_q;       // completion and interrupt events
  logic [8:0]  pl_q, dl_q;         // pulse width and debounce delay
  logic        irq_q;              // pending interrupt
  logic        out_q;              // pin level
  logic        aw_full_q, w_full_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;

  // rising edge of a sampled level
  function automatic logic rise(input logic now, input logic was);
    rise = now & ~was;
  endfunction

  // byte-lane merge into a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // decoded fields and input events
  mmct_mode_t mode;
  logic a_l, b_l, c_l, a_was, gate_act, gate_was;
  logic g_rise, g_fall, a_rise, b_rise, c_rise, tick, trig, updn;
  logic wr_go, ar_hs, ivec_rd, meas;
  logic [15:0] rback;
  assign mode     = mmct_mode_t'(ctrl_q[2:0]);
  assign a_l      = s2_q[0];
  assign b_l      = s2_q[1];
  assign c_l      = s2_q[2];
  assign a_was    = s3_q[0];
  assign gate_act = ctrl_q[`MMCT_B_GATEHI] ? a_l : ~a_l;
  assign gate_was = ctrl_q[`MMCT_B_GATEHI] ? a_was : ~a_was;
  assign g_rise   = rise(gate_act, gate_was);
  assign g_fall   = rise(gate_was, gate_act);
  assign a_rise   = rise(a_l, a_was);
  assign b_rise   = rise(b_l, s3_q[1]);
  assign c_rise   = rise(c_l, s3_q[2]);
  assign tick     = ctrl_q[`MMCT_B_EXTCLK] ? b_rise : dtick_q;
  assign updn     = (mode == MD_EVENT) & ctrl_q[`MMCT_B_UPDN];
  assign trig     = swtrig_q | (ctrl_q[`MMCT_B_TRGEXT] & c_rise & ~updn
                    & (mode != MD_QUAD));
  assign wr_go    = aw_full_q & w_full_q & ~bvalid_q;
  assign ar_hs    = s_axi_arvalid & arready_q;
  assign ivec_rd  = ar_hs & (s_axi_araddr == `MMCT_A_IVEC);
  assign meas     = (mode == MD_FREQ) | (mode == MD_PULSE) | (mode == MD_PERIOD);
  assign rback    = meas ? rb_q : cnt_q;

  // two-stage input sync, third stage for edges
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
    end
    else
    begin
      s1_q <= {trigger_index_input, clock_event_input, gate_reload_input};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // internal counting-clock enable
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      div_q   <= 4'h0;
      dtick_q <= 1'b0;
    end
    else
    begin
      dtick_q <= (div_q == `MMCT_DIV);
      div_q   <= (div_q == `MMCT_DIV) ? 4'h0 : div_q + 4'h1;
    end
  end

  // channel sequencer, one branch per mode, the three measuring modes sharing one
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      st_q   <= ST_IDLE;
      cnt_q  <= 16'h0000;
      rb_q   <= 16'h0000;
      act_q  <= 1'b0;
      done_q <= 1'b0;
      ev_q   <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      ev_q   <= 1'b0;
      case (mode)
        MD_PWM:
        begin
          if (trig)
          begin
            st_q  <= ST_RUN;
            cnt_q <= pre1_q;
            act_q <= 1'b0;
          end
          else if (st_q != ST_IDLE && tick && !gate_act)
          begin
            if (cnt_q > 16'h0001)
              cnt_q <= cnt_q - 16'h0001;
            else if (st_q == ST_RUN)
            begin
              st_q  <= ST_HIGH;
              cnt_q <= pre2_q;
              act_q <= 1'b1;
              ev_q  <= 1'b1;
            end
            else
            begin
              act_q <= 1'b0;
              ev_q  <= 1'b1;
              cnt_q <= pre1_q;
              st_q  <= ctrl_q[`MMCT_B_REPEAT] ? ST_RUN : ST_IDLE;
            end
          end
        end
        MD_WDOG:
        begin
          if (trig)
          begin
            st_q  <= ST_RUN;
            cnt_q <= pre1_q;
            act_q <= 1'b1;
          end
          else if (st_q == ST_RUN)
          begin
            if (g_rise)
              cnt_q <= pre1_q;
            else if (tick && cnt_q <= 16'h0001)
            begin
              cnt_q <= 16'h0000;
              act_q <= 1'b0;
              ev_q  <= 1'b1;
              st_q  <= ST_IDLE;
            end
            else if (tick)
              cnt_q <= cnt_q - 16'h0001;
          end
        end
        MD_EVENT:
        begin
          if (trig)
          begin
            st_q  <= ST_RUN;
            cnt_q <= 16'h0000;
          end
          else if (st_q == ST_RUN && b_rise && !gate_act)
          begin
            if (updn && !c_l)
              cnt_q <= cnt_q - 16'h0001;
            else
              cnt_q <= cnt_q + 16'h0001;
            if ((updn && !c_l ? cnt_q - 16'h0001 : cnt_q + 16'h0001) == pre1_q)
            begin
              ev_q   <= 1'b1;
              done_q <= 1'b1;
              st_q   <= ST_IDLE;
            end
          end
        end
        MD_FREQ, MD_PULSE, MD_PERIOD:
        begin
          if (trig)
            st_q <= ST_WAIT;
          else if (st_q == ST_WAIT && g_rise)
          begin
            st_q  <= ST_RUN;
            cnt_q <= 16'h0000;
          end
          else if (st_q == ST_RUN &&
                   (mode == MD_PERIOD ? g_rise : g_fall))
          begin
            rb_q   <= cnt_q;
            ev_q   <= 1'b1;
            done_q <= 1'b1;
            st_q   <= ST_IDLE;
          end
          else if (st_q == ST_RUN && (mode == MD_FREQ ? b_rise : tick))
            cnt_q <= cnt_q + 16'h0001;
        end
        MD_QUAD:
        begin
          if (trig)
          begin
            st_q  <= ST_RUN;
            cnt_q <= 16'h0000;
          end
          else if (st_q == ST_RUN)
          begin
            act_q <= c_l | (cnt_q == pre1_q);
            if (c_rise)
            begin
              ev_q <= 1'b1;
              if (ctrl_q[`MMCT_B_IDXLD])
                cnt_q <= pre2_q;
            end
            else if (a_rise)
            begin
              cnt_q <= b_l ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
              if ((b_l ? cnt_q - 16'h0001 : cnt_q + 16'h0001) == pre1_q)
                ev_q <= 1'b1;
            end
          end
        end
        default:
        begin
          st_q  <= ST_IDLE;
          act_q <= 1'b0;
        end
      endcase
    end
  end

  // completion pulse with optional debounce delay
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      pl_q <= 9'h000;
      dl_q <= 9'h000;
    end
    else if (done_q && ctrl_q[`MMCT_B_DEB])
      dl_q <= DEB_C;
    else if (done_q)
      pl_q <= PULSE_C;
    else if (dl_q != 9'h000)
    begin
      dl_q <= dl_q - 9'h001;
      if (dl_q == 9'h001)
        pl_q <= PULSE_C;
    end
    else if (pl_q != 9'h000)
      pl_q <= pl_q - 9'h001;
  end

  // pin level with programmed polarity
  always_ff @(posedge core_clk)
  begin
    if (reset)
      out_q <= 1'b1;
    else if (mode == MD_PWM || mode == MD_WDOG || mode == MD_QUAD)
      out_q <= act_q ~^ ctrl_q[`MMCT_B_POL];
    else if (mode == MD_OFF)
      out_q <= ~ctrl_q[`MMCT_B_POL];
    else
      out_q <= (pl_q != 9'h000) ~^ ctrl_q[`MMCT_B_POL];
  end

  // sticky interrupt request, set wins over acknowledge
  always_ff @(posedge core_clk)
  begin
    if (reset)
      irq_q <= 1'b0;
    else
      irq_q <= (ev_q & ctrl_q[`MMCT_B_IRQEN]) | (irq_q & ~ivec_rd);
  end

  // write address and data capture, either order
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end
    else
    begin
      awready_q <= s_axi_awvalid & ~awready_q & ~aw_full_q & ~bvalid_q;
      wready_q  <= s_axi_wvalid & ~wready_q & ~w_full_q & ~bvalid_q;
      if (s_axi_awvalid && awready_q)
      begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_full_q <= 1'b0;
      if (s_axi_wvalid && wready_q)
      begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      else if (wr_go)
        w_full_q <= 1'b0;
    end
  end

  // register writes and write response
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ctrl_q   <= `MMCT_CTRL_RST;
      pre1_q   <= 16'h0000;
      pre2_q   <= 16'h0000;
      ivec_q   <= 16'h0000;
      swtrig_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= 2'h0;
    end
    else
    begin
      swtrig_q <= 1'b0;
      if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
      if (wr_go)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= 2'h0;
        if (aw_addr_q == `MMCT_A_CTRL)
          ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q);
        else if (aw_addr_q == `MMCT_A_PRE1)
          pre1_q <= merge(pre1_q, w_data_q, w_strb_q);
        else if (aw_addr_q == `MMCT_A_PRE2)
          pre2_q <= merge(pre2_q, w_data_q, w_strb_q);
        else if (aw_addr_q == `MMCT_A_TRIG)
          swtrig_q <= w_data_q[0] & w_strb_q[0];
        else if (aw_addr_q == `MMCT_A_IVEC)
          ivec_q <= merge(ivec_q, w_data_q, w_strb_q);
        else
          bresp_q <= 2'h2;
      end
    end
  end

  // register reads, data one cycle after address
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= 2'h0;
    end
    else
    begin
      arready_q <= s_axi_arvalid & ~arready_q & ~rvalid_q;
      if (rvalid_q && s_axi_rready)
        rvalid_q <= 1'b0;
      if (ar_hs)
      begin
        rvalid_q <= 1'b1;
        rresp_q  <= 2'h0;
        rdata_q  <= 32'h0000_0000;
        if (s_axi_araddr == `MMCT_A_CTRL)
          rdata_q[15:0] <= ctrl_q;
        else if (s_axi_araddr == `MMCT_A_PRE1)
          rdata_q[15:0] <= pre1_q;
        else if (s_axi_araddr == `MMCT_A_PRE2)
          rdata_q[15:0] <= pre2_q;
        else if (s_axi_araddr == `MMCT_A_TRIG)
          rdata_q[15:0] <= 16'h0000;
        else if (s_axi_araddr == `MMCT_A_RBACK)
          rdata_q[15:0] <= rback;
        else if (s_axi_araddr == `MMCT_A_STAT)
          rdata_q[15:0] <= {12'h000, out_q, act_q, st_q != ST_IDLE, irq_q};
        else if (s_axi_araddr == `MMCT_A_IVEC)
          rdata_q[15:0] <= ivec_q;
        else if (s_axi_araddr == `MMCT_A_ID)
          rdata_q[15:0] <= `MMCT_ID_CODE;
        else
          rresp_q <= 2'h2;
      end
    end
  end

  assign s_axi_awready  = awready_q;
  assign s_axi_wready   = wready_q;
  assign s_axi_bvalid   = bvalid_q;
  assign s_axi_bresp    = bresp_q;
  assign s_axi_arready  = arready_q;
  assign s_axi_rvalid   = rvalid_q;
  assign s_axi_rdata    = rdata_q;
  assign s_axi_rresp    = rresp_q;
  assign channel_output = out_q;
  assign irq_req        = irq_q;

  // checks on the channel behaviour
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_done_deb;
    done_q && ctrl_q[`MMCT_B_DEB];
  endsequence

  a_gate_freeze: assert property (
    mode == MD_PWM && !trig && gate_act && !swtrig_q |=> $stable(cnt_q))
    else $error("count moved while gated");
  a_phase_load: assert property (
    mode == MD_PWM && !trig && st_q == ST_RUN && tick && !gate_act
    && cnt_q <= 16'h0001 |=> act_q && cnt_q == $past(pre2_q))
    else $error("active phase not loaded");
  a_wdog_end: assert property (
    mode == MD_WDOG && !trig && st_q == ST_RUN && !g_rise && tick
    && cnt_q == 16'h0001 |=> !act_q && ev_q ##1 irq_q == ctrl_q[`MMCT_B_IRQEN])
    else $error("watchdog end wrong");
  a_pulse_len: assert property (
    done_q && !ctrl_q[`MMCT_B_DEB] |=> pl_q == PULSE_C ##1 pl_q == PULSE_C - 9'h001)
    else $error("completion pulse width wrong");
  a_deb_delay: assert property (
    s_done_deb |=> dl_q == DEB_C && pl_q == 9'h000)
    else $error("debounce delay missing");
  a_meas_latch: assert property (
    meas && !trig && st_q == ST_RUN && mode == MD_FREQ && g_fall
    |=> rb_q == $past(cnt_q) && ev_q && st_q == ST_IDLE)
    else $error("measurement not latched");
  a_quad_index: assert property (
    mode == MD_QUAD && !trig && st_q == ST_RUN && c_rise && ctrl_q[`MMCT_B_IDXLD]
    |=> cnt_q == $past(pre2_q) && ev_q)
    else $error("index reload missing");
  a_irq_hold: assert property (
    irq_q && !ivec_rd |=> irq_q)
    else $error("interrupt dropped unacknowledged");
  a_read_ack: assert property (
    ar_hs |=> rvalid_q)
    else $error("read not acknowledged");
  a_id_ro: assert property (
    wr_go && aw_addr_q == `MMCT_A_ID |=> bvalid_q && bresp_q == 2'h2)
    else $error("identification write accepted");
endmodule

// file: rtl/mmct_params.svh
// constants for the counter/timer channel: offsets, ctrl fields, timing
// assumes a 125 MHz core clock and a byte-addressed AXI4-Lite slave
`ifndef MMCT_PARAMS_SVH
`define MMCT_PARAMS_SVH
`define MMCT_A_CTRL   8'h00
`define MMCT_A_PRE1   8'h04
`define MMCT_A_PRE2   8'h08
`define MMCT_A_TRIG   8'h0C
`define MMCT_A_RBACK  8'h10
`define MMCT_A_STAT   8'h14
`define MMCT_A_IVEC   8'h20
`define MMCT_A_ID     8'h40
`define MMCT_B_POL    3
`define MMCT_B_GATEHI 4
`define MMCT_B_EXTCLK 5
`define MMCT_B_TRGEXT 6
`define MMCT_B_UPDN   7
`define MMCT_B_DEB    8
`define MMCT_B_IRQEN  9
`define MMCT_B_IDXLD  10
`define MMCT_B_REPEAT 11
`define MMCT_CTRL_RST 16'h0007
`define MMCT_ID_CODE  16'h5A5A // identification word, value arbitrary
`define MMCT_CLK_NS   8
`define MMCT_PULSE_NS 1750
`define MMCT_DEB_NS   2500
`define MMCT_DIV      4'hF
`endif

// file: rtl/mmct_pkg.sv
// types for the counter/timer channel
// shared by the channel module and the bench
package mmct_pkg;
  // counting modes, held in ctrl[2:0]
  typedef enum logic [2:0] {
    MD_PWM, MD_WDOG, MD_EVENT, MD_FREQ, MD_PULSE, MD_PERIOD, MD_QUAD, MD_OFF
  } mmct_mode_t;
  // channel sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN, ST_HIGH} mmct_state_t;
endpackage

// file: tb/mmct_field_model.sv
// field-side model: gate, event and trigger/index pins of one channel
// assumes its tasks are called just after a rising core_clk edge
`timescale 1ns/1ns
module mmct_field_model
(
  input  wire logic core_clk,
  output logic      gate_reload_input,
  output logic      clock_event_input,
  output logic      trigger_index_input
);
  // idle field levels at time zero
  initial
  begin
    gate_reload_input = 1'b0;
    clock_event_input = 1'b0;
    trigger_index_input = 1'b0;
  end
  // static gate and trigger/index levels
  task automatic set_pins(input logic g, input logic c);
    gate_reload_input <= g;
    trigger_index_input <= c;
  endtask
  task automatic pulse(input bit on_a, input int n, input int w);
    repeat (n)
    begin
      if (on_a) gate_reload_input <= 1'b1;
      else clock_event_input <= 1'b1;
      repeat (w) @(posedge core_clk);
      if (on_a) gate_reload_input <= 1'b0;
      else clock_event_input <= 1'b0;
      repeat (w) @(posedge core_clk);
    end
  endtask
endmodule

// file: tb/multimode_counter_timer_test.sv
// self-checking bench for one counter/timer channel
// acts as AXI4-Lite master; field pins come from mmct_field_model
`timescale 1ns/1ns
`include "mmct_params.svh"
`define CK(nm, ex, got) \
  begin n_tests++; if ((got) !== (ex)) begin n_fail++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module multimode_counter_timer_test
  import mmct_pkg::*;
;
  localparam int TK = `MMCT_DIV + 1;           // internal tick in clocks
  logic        core_clk, reset;                // clock, sync reset
  logic [7:0]  s_axi_awaddr, s_axi_araddr;     // byte addresses
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;   // data words
  logic [3:0]  s_axi_wstrb;                    // byte lanes
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;   // responses
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;     // read handshake
  logic        gate_reload_input, clock_event_input, trigger_index_input;
  logic        channel_output, irq_req;        // channel outputs
  logic [31:0] seed_q;                         // prng state
  logic [7:0]  wa [3] = '{`MMCT_A_PRE1, `MMCT_A_PRE2, `MMCT_A_IVEC};
  int          n_fail, n_tests, w, t, m, k;    // counters and spans
  // device under test
  mmct_channel dut
  (
    .core_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gate_reload_input,
    .clock_event_input, .trigger_index_input, .channel_output, .irq_req
  );
  // far-side field signals
  mmct_field_model field
  (
    .core_clk, .gate_reload_input, .clock_event_input, .trigger_index_input
  );
  // 125 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // xorshift source of random values
  function automatic logic [31:0] xs();
    seed_q = seed_q ^ (seed_q << 13);
    seed_q = seed_q ^ (seed_q >> 17);
    seed_q = seed_q ^ (seed_q << 5);
    return seed_q;
  endfunction
  // control word: active-high output and gate, interrupt on
  function automatic logic [15:0] ctrl_of(input mmct_mode_t md);
    return (16'h0001 << `MMCT_B_POL) | (16'h0001 << `MMCT_B_GATEHI)
         | (16'h0001 << `MMCT_B_IRQEN) | {13'h0000, md};
  endfunction
  // a time in clock cycles, rounded up
  function automatic int cyc_of(input int ns);
    return (ns + `MMCT_CLK_NS - 1) / `MMCT_CLK_NS;
  endfunction
  // verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // write one word; address and data offered together
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    rs = 2'bxx;
    // no cycle count assumed; only the hang guard ends a lost answer
    forever
    begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        rs = s_axi_bresp;
        break;
      end
    end
    s_axi_bready <= 1'b0;
  endtask
  // read one word into rd and rs
  task automatic rdw(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    rd = 'x;
    forever
    begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        break;
      end
    end
    s_axi_rready <= 1'b0;
  endtask
  // read and compare a whole word
  task automatic rdc(input logic [7:0] a, input logic [31:0] ex, input string nm);
    rdw(a);
    `CK(nm, ex, rd)
  endtask
  // wait up to lim cycles for an output level; t counts them
  task automatic wo(input logic lvl, input int lim);
    t = 0;
    while (channel_output !== lvl && t < lim)
    begin
      @(posedge core_clk);
      t++;
    end
  endtask
  // vector read acknowledges the interrupt
  task automatic clr();
    rdw(`MMCT_A_IVEC);
    repeat (2) @(posedge core_clk);
    `CK("irq clear", 1'b0, irq_req)
  endtask
  // hang guard, well past the expected run
  initial
  begin
    repeat (40000) @(posedge core_clk);
    n_fail++;
    test_done();
  end
  // main sequence
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    seed_q = 32'h0DF6;
    n_fail = 0;
    n_tests = 0;
    reset = 1'b1;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    // reset levels, identity, refusals
    @(posedge core_clk);
    `CK("out reset", 1'b1, channel_output)
    `CK("irq reset", 1'b0, irq_req)
    rdc(`MMCT_A_CTRL, `MMCT_CTRL_RST, "ctrl reset");
    rdc(`MMCT_A_ID, `MMCT_ID_CODE, "id");
    wr(`MMCT_A_ID, 16'h0000);
    `CK("id wr resp", 2'h2, rs)
    rdc(`MMCT_A_ID, `MMCT_ID_CODE, "id kept");
    rdw(8'h3C);
    `CK("unmapped resp", 2'h2, rs)
    `CK("unmapped data", 32'h0000_0000, rd)
    // random words in the two presets and the vector register
    foreach (wa[i])
    begin
      k = xs() & 32'h0000_FFFF;
      wr(wa[i], k[15:0]);
      `CK("wr resp", 2'h0, rs)
      rdc(wa[i], k, "rw word");
    end
    // event count with up/down on the third input
    w = 3 + (xs() & 3);
    m = 3 + (xs() & 3);
    wr(`MMCT_A_CTRL, ctrl_of(MD_EVENT) | (16'h0001 << `MMCT_B_UPDN));
    wr(`MMCT_A_PRE1, m[15:0]);
    wr(`MMCT_A_TRIG, 16'h0001);
    field.set_pins(1'b0, 1'b1);
    repeat (4) @(posedge core_clk);
    field.pulse(1'b0, 2, w);
    field.set_pins(1'b0, 1'b0);
    repeat (4) @(posedge core_clk);
    field.pulse(1'b0, 1, w);
    rdc(`MMCT_A_RBACK, 32'h1, "up down");
    // count to the limit, paused by the gate on the way
    wr(`MMCT_A_CTRL, ctrl_of(MD_EVENT));
    wr(`MMCT_A_TRIG, 16'h0001);
    field.pulse(1'b0, m - 1, w);
    rdc(`MMCT_A_RBACK, m - 1, "live count");
    field.set_pins(1'b1, 1'b0);
    repeat (4) @(posedge core_clk);
    field.pulse(1'b0, 2, w);
    rdc(`MMCT_A_RBACK, m - 1, "paused count");
    field.set_pins(1'b0, 1'b0);
    repeat (4) @(posedge core_clk);
    `CK("irq early", 1'b0, irq_req)
    fork
      field.pulse(1'b0, 1, w);
      begin
        wo(1'b1, 100);
        wo(1'b0, 400);
      end
    join
    `CK("done pulse", cyc_of(`MMCT_PULSE_NS), t)
    `CK("irq limit", 1'b1, irq_req)
    repeat (30) @(posedge core_clk);
    `CK("irq held", 1'b1, irq_req)
    clr();
    // watchdog: active from trigger until zero
    m = 4 + (xs() & 3);
    wr(`MMCT_A_CTRL, ctrl_of(MD_WDOG) | (16'h0001 << `MMCT_B_TRGEXT));
    wr(`MMCT_A_PRE1, m[15:0]);
    // rising third input starts the count
    field.set_pins(1'b0, 1'b1);
    repeat (6) @(posedge core_clk);
    `CK("wdog active", 1'b1, channel_output)
    rdw(`MMCT_A_RBACK);
    `CK("wdog live", 1'b1, rd <= m && rd != 0)
    wo(1'b0, m * TK + 64);
    `CK("wdog span", 1'b1, t >= (m - 2) * TK && t <= m * TK)
    repeat (3) @(posedge core_clk);
    `CK("wdog irq", 1'b1, irq_req)
    clr();
    // frequency with debounce: early events ignored
    k = 2 + (xs() & 7);
    wr(`MMCT_A_CTRL, ctrl_of(MD_FREQ) | (16'h0001 << `MMCT_B_DEB));
    wr(`MMCT_A_TRIG, 16'h0001);
    field.pulse(1'b0, 2, w);
    field.set_pins(1'b1, 1'b0);
    repeat (4) @(posedge core_clk);
    field.pulse(1'b0, k, w);
    field.set_pins(1'b0, 1'b0);
    wo(1'b1, 500);
    `CK("deb delay", 1'b1, t >= cyc_of(`MMCT_DEB_NS) && t <= cyc_of(`MMCT_DEB_NS) + 8)
    wo(1'b0, 400);
    `CK("freq pulse", cyc_of(`MMCT_PULSE_NS), t)
    `CK("freq irq", 1'b1, irq_req)
    rdc(`MMCT_A_RBACK, k, "freq count");
    clr();
    // pulse then period on one waveform, partial pulse first
    m = 3 + (xs() & 3);
    for (int i = 0; i < 2; i++)
    begin
      wr(`MMCT_A_CTRL, ctrl_of(i ? MD_PERIOD : MD_PULSE));
      field.set_pins(1'b1, 1'b0);
      wr(`MMCT_A_TRIG, 16'h0001);
      repeat (8) @(posedge core_clk);
      field.set_pins(1'b0, 1'b0);
      repeat (40) @(posedge core_clk);
      field.set_pins(1'b1, 1'b0);
      repeat (m * TK) @(posedge core_clk);
      field.set_pins(1'b0, 1'b0);
      repeat (m * TK) @(posedge core_clk);
      field.set_pins(1'b1, 1'b0);
      repeat (40) @(posedge core_clk);
      field.set_pins(1'b0, 1'b0);
      repeat (8) @(posedge core_clk);
      `CK("meas irq", 1'b1, irq_req)
      rdw(`MMCT_A_RBACK);
      `CK("meas span", 1'b1, rd + 1 >= m * (i + 1) && rd <= m * (i + 1) + 1)
      clr();
    end
    // quadrature: limit match, index level and reload
    k = 32'h0100 + (xs() & 32'h00FF);
    wr(`MMCT_A_CTRL, ctrl_of(MD_QUAD) | (16'h0001 << `MMCT_B_IDXLD));
    wr(`MMCT_A_PRE1, 16'h0003);
    wr(`MMCT_A_PRE2, k[15:0]);
    wr(`MMCT_A_TRIG, 16'h0001);
    field.pulse(1'b1, 3, w);
    `CK("quad limit out", 1'b1, channel_output)
    `CK("quad limit irq", 1'b1, irq_req)
    clr();
    field.set_pins(1'b0, 1'b1);
    repeat (8) @(posedge core_clk);
    `CK("index out", 1'b1, channel_output)
    `CK("index irq", 1'b1, irq_req)
    rdc(`MMCT_A_RBACK, k, "index reload");
    field.set_pins(1'b0, 1'b0);
    repeat (8) @(posedge core_clk);
    `CK("quad idle", 1'b0, channel_output)
    // generation: preset one idle, preset two active
    wr(`MMCT_A_CTRL, ctrl_of(MD_PWM));
    wr(`MMCT_A_PRE1, 16'h0002);
    wr(`MMCT_A_PRE2, 16'h0003);
    wr(`MMCT_A_TRIG, 16'h0001);
    wo(1'b1, 200);
    `CK("idle span", 1'b1, t >= TK && t <= 3 * TK)
    // gate held two ticks stretches the active phase
    field.set_pins(1'b1, 1'b0);
    repeat (2 * TK) @(posedge core_clk);
    field.set_pins(1'b0, 1'b0);
    wo(1'b0, 200);
    `CK("active span", 1'b1, t >= 3 * TK - 8 && t <= 3 * TK + 8)
    test_done();
  end
endmodule
